// ---- core/prds_top.sv ----
// prds_top: pwm auto-restart, active-edge delay and output steering.
// assumes clk is the instruction clock and the timebase, duty compare
// and shutdown source arrive as synchronous inputs.
// Function
// [R1] no restart-enable: hold off until software clears
// [R2] restart-enable: status self-clears when shutdown ends
// [R3] delay active edges by seven-bit count
// [R4] sync bit: steering change at period start
// [R5] steer b routes waveform to pin b
// [R6] steer a routes waveform to pin a
// [R7] steering only with mode 11, config 00
// [R8] reserved steering bits read as zero
// [R9] top three steering bits unimplemented, zero
// [R10] steering resets with only enable a set
`timescale 1ns/1ps
module prds_top (
  input  wire logic        clk,             // instruction clock
  input  wire logic        reset,           // synchronous, active high
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        pwm_raw,         // undelayed waveform from timebase
  input  wire logic        period_start,    // pulse at each new pwm period
  input  wire logic        shutdown_in,     // shutdown condition level
  input  wire logic        port_a_out,      // ordinary port data for pin a
  input  wire logic        port_b_out,      // ordinary port data for pin b
  output logic             pwm_out_pin_a,
  output logic             pwm_out_pin_b,
  output logic             steer_active_a,  // pin a owned by pwm
  output logic             steer_active_b,  // pin b owned by pwm
  output logic             shutdown_active  // outputs held in shutdown state
);
  import prds_pkg::*;

  // software registers and internal state
  logic [7:0]  restart_delay_reg;           // rsen + delay count
  prds_steer_t steer_reg;                   // software-written steering
  prds_steer_t steer_live_reg;              // steering in force
  prds_mode_t  mode_reg;                    // ccm high, polarity, out cfg
  logic        ase_reg;                     // shutdown_event_status
  logic [PRDS_DELAY_W-1:0] delay_cnt_reg;   // active-edge delay counter
  logic        pwm_dly_reg;                 // delayed waveform
  logic        raw_prev_reg;                // last sampled raw waveform

  // address phase capture
  logic        dp_valid_reg;
  logic        dp_write_reg;
  logic [7:0]  dp_addr_reg;

  // pulled-out fields
  wire         auto_restart_enable = restart_delay_reg[PRDS_RSEN_BIT];
  wire [PRDS_DELAY_W-1:0] active_delay_count = restart_delay_reg[PRDS_DELAY_W-1:0];

  // register read mux helper, used for read data only; writes decode dp_addr_reg directly
  function automatic logic [7:0] prds_read(input logic [7:0] a, input logic [7:0] rd,
                                           input prds_steer_t s, input prds_mode_t m,
                                           input logic ase);
    case (a)
      PRDS_RESTART_DELAY_OFS: prds_read = rd;
      // unimplemented and reserved bits fold to zero
      PRDS_STEERING_OFS:      prds_read = {3'h0, s.sync_sel, 2'h0, s.en_b, s.en_a}; // see [R8] see [R9]
      PRDS_MODE_OFS:          prds_read = {2'h0, m};
      PRDS_STATUS_OFS:        prds_read = {7'h00, ase};
      default:                prds_read = 8'h00;
    endcase
  endfunction

  // word address from the low byte lane; upper address bits alias onto
  // the same four registers, a trade made to keep the decode small
  function automatic logic [7:0] prds_word(input logic [31:0] a);
    prds_word = {a[7:2], 2'b00};
  endfunction

  // bus decode
  wire addr_take  = hsel && hready && (htrans == PRDS_HTRANS_NONSEQ || htrans == PRDS_HTRANS_SEQ);
  wire wr_now     = dp_valid_reg && dp_write_reg;
  wire wr_rd      = wr_now && dp_addr_reg == PRDS_RESTART_DELAY_OFS;
  wire wr_steer   = wr_now && dp_addr_reg == PRDS_STEERING_OFS;
  wire wr_mode    = wr_now && dp_addr_reg == PRDS_MODE_OFS;
  wire wr_status  = wr_now && dp_addr_reg == PRDS_STATUS_OFS;
  // software clears status by writing zero to bit 0
  wire ase_sw_clr = wr_status && !hwdata[PRDS_ASE_BIT];

  // steering allowed only in enhanced pwm single-output mode
  wire steer_mode_ok = (mode_reg.ccm_high == 2'h3) && (mode_reg.out_cfg == 2'h0); // see [R7]

  // steering takes effect now, or at the next period when sync is set
  wire steer_apply = !steer_reg.sync_sel || period_start; // see [R4]

  // waveform with polarity from the mode polarity field (its bit 0 inverts)
  wire pwm_pol = pwm_dly_reg ^ mode_reg.polarity[0];

  // auto-restart clears status once the shutdown input has gone away
  wire ase_hw_clr = auto_restart_enable && !shutdown_in; // see [R2]

  assign hreadyout = 1'b1;  // zero wait states
  assign hresp     = 1'b0;  // always okay

  // address phase capture; no wait states so hready is always ours
  always_ff @(posedge clk) begin
    if (reset) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 8'h00;
    end else begin
      dp_valid_reg <= addr_take;
      dp_write_reg <= hwrite;
      dp_addr_reg  <= prds_word(haddr);
    end
  end

  // read data registered at the address phase, ready in the data phase
  // limitation: a read whose address phase overlaps the data phase of a
  // write to the same register returns the old value; a master that
  // needs the new value leaves one idle cycle between the two
  always_ff @(posedge clk) begin
    if (reset) begin
      hrdata <= 32'h00000000;
    end else if (addr_take && !hwrite) begin
      hrdata <= {24'h000000, prds_read(prds_word(haddr), restart_delay_reg,
                                       steer_reg, mode_reg, ase_reg)};
    end
  end

  // control registers
  always_ff @(posedge clk) begin
    if (reset) begin
      restart_delay_reg <= PRDS_RESTART_DELAY_RST;
      steer_reg         <= PRDS_STEERING_RST[2:0] | 3'h0; // see [R10]
      mode_reg          <= PRDS_MODE_RST[5:0];
    end else begin
      if (wr_rd) begin
        restart_delay_reg <= hwdata[7:0];
      end
      if (wr_steer) begin
        // only bits 4,1,0 stored; reserved and top bits dropped
        steer_reg <= {hwdata[PRDS_SYNC_BIT], hwdata[PRDS_STR_B_BIT], hwdata[PRDS_STR_A_BIT]}; // see [R9]
      end
      if (wr_mode) begin
        mode_reg <= hwdata[5:0];
      end
    end
  end

  // live steering copy, updated per sync selection
  always_ff @(posedge clk) begin
    if (reset) begin
      steer_live_reg <= PRDS_STEERING_RST[2:0]; // see [R10]
    end else if (steer_apply) begin
      steer_live_reg <= steer_reg; // see [R4]
    end
  end

  // shutdown event status: set wins over any clear
  always_ff @(posedge clk) begin
    if (reset) begin
      ase_reg <= 1'b0;
    end else if (shutdown_in) begin
      ase_reg <= 1'b1;
    end else if (ase_hw_clr || ase_sw_clr) begin
      // without restart-enable only software releases it
      ase_reg <= 1'b0; // see [R1] see [R2]
    end
  end

  // active-edge delay: rising edge waits count cycles, falling is immediate
  always_ff @(posedge clk) begin
    if (reset) begin
      raw_prev_reg  <= 1'b0;
      delay_cnt_reg <= '0;
      pwm_dly_reg   <= 1'b0;
    end else begin
      raw_prev_reg <= pwm_raw;
      if (!pwm_raw) begin
        pwm_dly_reg   <= 1'b0;
        delay_cnt_reg <= '0;
      end else if (!raw_prev_reg) begin
        // scheduled transition; zero count goes active at once
        pwm_dly_reg   <= (active_delay_count == '0); // see [R3]
        delay_cnt_reg <= active_delay_count;
      end else if (!pwm_dly_reg) begin
        if (delay_cnt_reg <= 7'h01) begin
          pwm_dly_reg <= 1'b1; // see [R3]
        end
        delay_cnt_reg <= delay_cnt_reg - 7'h01;
      end
    end
  end

  // pin ownership and drive; the shutdown drive level, low, is set in the pin registers below
  assign steer_active_a  = steer_mode_ok && steer_live_reg.en_a; // see [R6] see [R7]
  assign steer_active_b  = steer_mode_ok && steer_live_reg.en_b; // see [R5] see [R7]
  assign shutdown_active = ase_reg; // see [R1]

  // pin outputs registered; a shut-down owned pin is forced low, whatever the polarity
  always_ff @(posedge clk) begin
    if (reset) begin
      pwm_out_pin_a <= 1'b0;
      pwm_out_pin_b <= 1'b0;
    end else begin
      pwm_out_pin_a <= steer_active_a ? (pwm_pol && !ase_reg) : port_a_out; // see [R6]
      pwm_out_pin_b <= steer_active_b ? (pwm_pol && !ase_reg) : port_b_out; // see [R5]
    end
  end

  // status stays set while no restart-enable and no software write
  a_manual_hold: assert property (@(posedge clk) disable iff (reset) // see [R1]
    ase_reg && !auto_restart_enable && !ase_sw_clr |=> ase_reg)
    else $error("status dropped without software clear");

  a_auto_clear: assert property (@(posedge clk) disable iff (reset) // see [R2]
    ase_reg && auto_restart_enable && !shutdown_in |=> !ase_reg)
    else $error("auto restart did not clear status");

  sequence s_rise_d1;
    !raw_prev_reg && pwm_raw && active_delay_count == 7'h01;
  endsequence
  a_delay_one: assert property (@(posedge clk) disable iff (reset) // see [R3]
    s_rise_d1 ##1 pwm_raw |=> pwm_dly_reg)
    else $error("delay of one not honoured");

  a_delay_early: assert property (@(posedge clk) disable iff (reset) // see [R3]
    !raw_prev_reg && pwm_raw && active_delay_count > 7'h01 |=> !pwm_dly_reg)
    else $error("active edge came early");

  a_sync_hold: assert property (@(posedge clk) disable iff (reset) // see [R4]
    steer_reg.sync_sel && !period_start |=> $stable(steer_live_reg))
    else $error("steering changed outside period start");

  a_mode_gate: assert property (@(posedge clk) disable iff (reset) // see [R7]
    mode_reg.ccm_high != 2'h3 |-> !steer_active_a && !steer_active_b)
    else $error("steering active outside steering mode");

  a_port_pin_b: assert property (@(posedge clk) disable iff (reset) // see [R5]
    !steer_active_b |=> pwm_out_pin_b == $past(port_b_out))
    else $error("pin b not following port");

  a_port_pin_a: assert property (@(posedge clk) disable iff (reset) // see [R6]
    !steer_active_a |=> pwm_out_pin_a == $past(port_a_out))
    else $error("pin a not following port");

  a_steer_zero: assert property (@(posedge clk) disable iff (reset) // see [R8] see [R9]
    dp_valid_reg && !dp_write_reg && dp_addr_reg == PRDS_STEERING_OFS |-> hrdata[7:5] == 3'h0
    && hrdata[3:2] == 2'h0)
    else $error("steering reserved bits not zero");

  // a live shutdown condition always raises the status bit
  a_status_set: assert property (@(posedge clk) disable iff (reset) // see [R1]
    shutdown_in |=> ase_reg)
    else $error("shutdown did not set status");

  // while shut down an owned pin is held low, whatever the polarity
  a_shut_pin_a: assert property (@(posedge clk) disable iff (reset) // see [R1]
    ase_reg && steer_active_a |=> !pwm_out_pin_a)
    else $error("pin a active during shutdown");

  a_shut_pin_b: assert property (@(posedge clk) disable iff (reset) // see [R1]
    ase_reg && steer_active_b |=> !pwm_out_pin_b)
    else $error("pin b active during shutdown");

  // zero count: the active edge is not held back at all
  sequence s_rise_d0;
    !raw_prev_reg && pwm_raw && active_delay_count == 7'h00;
  endsequence
  a_delay_zero: assert property (@(posedge clk) disable iff (reset) // see [R3]
    s_rise_d0 |=> pwm_dly_reg)
    else $error("zero delay held the edge");

  // the inactive edge is never delayed
  a_delay_fall: assert property (@(posedge clk) disable iff (reset) // see [R3]
    !pwm_raw |=> !pwm_dly_reg)
    else $error("inactive edge delayed");

  // without sync the live copy trails the software copy by one cycle
  a_live_follow: assert property (@(posedge clk) disable iff (reset) // see [R4]
    !steer_reg.sync_sel |=> steer_live_reg == $past(steer_reg))
    else $error("steering did not follow at cycle boundary");

  // owned pins carry the polarity-adjusted, shutdown-gated waveform
  a_pwm_pin_a: assert property (@(posedge clk) disable iff (reset) // see [R6]
    steer_active_a |=> pwm_out_pin_a == ($past(pwm_pol) && !$past(ase_reg)))
    else $error("pin a not carrying waveform");

  a_pwm_pin_b: assert property (@(posedge clk) disable iff (reset) // see [R5]
    steer_active_b |=> pwm_out_pin_b == ($past(pwm_pol) && !$past(ase_reg)))
    else $error("pin b not carrying waveform");

  // only the three implemented steering bits are stored
  a_steer_write: assert property (@(posedge clk) disable iff (reset) // see [R9]
    wr_steer |=> steer_reg.sync_sel == $past(hwdata[PRDS_SYNC_BIT])
    && steer_reg.en_b == $past(hwdata[PRDS_STR_B_BIT]) && steer_reg.en_a == $past(hwdata[PRDS_STR_A_BIT]))
    else $error("steering write not stored");

endmodule

// ---- inc/prds_pkg.sv ----
// prds_pkg: register map, field positions, reset values and carriers
// for the pwm restart, active-delay and steering block.
// assumes a 32-bit ahb-lite register bus, one aligned word per register.
package prds_pkg;

  // register byte addresses (one aligned word each)
  localparam logic [7:0] PRDS_RESTART_DELAY_OFS = 8'h00; // pwm_restart_delay_control
  localparam logic [7:0] PRDS_STEERING_OFS      = 8'h04; // pwm_output_steering_control
  localparam logic [7:0] PRDS_MODE_OFS          = 8'h08; // capture_compare / output config
  localparam logic [7:0] PRDS_STATUS_OFS        = 8'h0C; // shutdown status

  // reset values
  localparam logic [7:0] PRDS_RESTART_DELAY_RST = 8'h00;
  localparam logic [7:0] PRDS_STEERING_RST      = 8'h01;
  localparam logic [7:0] PRDS_MODE_RST          = 8'h00;

  // field positions
  localparam int PRDS_RSEN_BIT     = 7;
  localparam int PRDS_SYNC_BIT     = 4;
  localparam int PRDS_STR_B_BIT    = 1;
  localparam int PRDS_STR_A_BIT    = 0;
  localparam int PRDS_ASE_BIT      = 0;
  localparam logic [7:0] PRDS_STEER_WMASK = 8'h13; // bits 4,1,0 writable

  // one instruction cycle is four oscillator periods; the core clock
  // is the instruction clock, so each delay unit is one clk cycle
  localparam int PRDS_DELAY_W = 7;

  // ahb-lite encodings
  localparam logic [1:0] PRDS_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PRDS_HTRANS_SEQ    = 2'h3;

  // steering request carried between shadow and live copies
  typedef struct packed {
    logic sync_sel;
    logic en_b;
    logic en_a;
  } prds_steer_t;

  // mode fields (upper capture/compare bits, polarity, output config)
  typedef struct packed {
    logic [1:0] ccm_high;
    logic [1:0] polarity;
    logic [1:0] out_cfg;
  } prds_mode_t;

endpackage

// ---- tb/prds_load.sv ----
// prds_load: behavioural load (gate driver) on the two pwm pins.
// assumes registered pins on the same clock as the block.
`timescale 1ns/1ps
module prds_load (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic pin_a,
  input  wire logic pin_b,
  output logic      on_a,
  output logic      on_b
);
  // switch follows its pin one cycle late; no memory beyond that
  always_ff @(posedge clk) begin
    if (reset) begin
      on_a <= 1'b0;
      on_b <= 1'b0;
    end else begin
      on_a <= pin_a;
      on_b <= pin_b;
    end
  end
endmodule

// ---- tb/prds_top_tb.sv ----
// prds_top_tb: register, delay, steering and shutdown tests.
// assumes one ahb-lite master (this bench) and a load on both pins.
`timescale 1ns/1ps
module prds_top_tb;
  import prds_pkg::*;
  logic        clk, reset, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        pwm_raw, period_start, shutdown_in, port_a_out, port_b_out;
  logic        pin_a, pin_b, act_a, act_b, sd_act, on_a, on_b;
  int          err_total, checked, l0, ln;
  logic [31:0] bad [3] = '{32'h31, 32'h20, 32'h10}; // modes that forbid steering
  assign hready = hreadyout; // single slave
  prds_top prds_top_i (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pwm_raw(pwm_raw), .period_start(period_start),
    .shutdown_in(shutdown_in), .port_a_out(port_a_out), .port_b_out(port_b_out),
    .pwm_out_pin_a(pin_a), .pwm_out_pin_b(pin_b), .steer_active_a(act_a),
    .steer_active_b(act_b), .shutdown_active(sd_act));
  prds_load prds_load_i (.clk(clk), .reset(reset), .pin_a(pin_a), .pin_b(pin_b), .on_a(on_a), .on_b(on_b));
  // 25 mhz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task finish_test;
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // checks land mid-cycle, away from edge updates
  task settle;
    @(negedge clk);
  endtask
  // one single transfer; waits on hready, never on a cycle count
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= PRDS_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), exp, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  // cycles from a pwm rise to the load switching on
  task lat(output int n);
    @(posedge clk);
    pwm_raw <= 1'b0;
    cyc(4);
    pwm_raw <= 1'b1;
    n = 0;
    while (on_a !== 1'b1 && n < 300) begin
      settle;
      n++;
    end
  endtask
  task shut_pulse;
    @(posedge clk);
    shutdown_in <= 1'b1;
    cyc(3);
    shutdown_in <= 1'b0;
  endtask
  // hang guard: whole run needs about 300 cycles
  initial begin
    #(40 * 8000);
    err_total++;
    finish_test;
  end
  initial begin
    {reset, hsize} = {1'b1, 3'h2};
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    {pwm_raw, period_start, shutdown_in, port_a_out, port_b_out} = 5'b00011;
    {err_total, checked} = '0;
    cyc(10);
    reset <= 1'b0;
    rchk(PRDS_STEERING_OFS, 32'h01);
    rchk(PRDS_RESTART_DELAY_OFS, 32'h00);
    bus(1'b1, PRDS_STEERING_OFS, 32'hFFFFFFFF);
    rchk(PRDS_STEERING_OFS, 32'h13);
    rchk(8'h10, 32'h0);
    bus(1'b1, PRDS_STEERING_OFS, 32'h03);
    bus(1'b1, PRDS_MODE_OFS, 32'h30);
    pwm_raw <= 1'b1;
    cyc(4);
    settle;
    chk("steer a", 32'h1, {31'h0, act_a});
    chk("steer b", 32'h1, {31'h0, act_b});
    chk("load b", 32'h1, {31'h0, on_b});
    bus(1'b1, PRDS_MODE_OFS, 32'h34); // polarity inverted
    cyc(4);
    settle;
    chk("load a", 32'h0, {31'h0, on_a});
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, PRDS_MODE_OFS, bad[i]);
      cyc(4);
      settle;
      chk("steer a", 32'h0, {31'h0, act_a});
      chk("load a", 32'h1, {31'h0, on_a});
    end
    bus(1'b1, PRDS_MODE_OFS, 32'h30);
    lat(l0);
    for (int d = 5; d < 130; d += 122) begin
      bus(1'b1, PRDS_RESTART_DELAY_OFS, d);
      lat(ln);
      chk("delay", d, ln - l0);
    end
    bus(1'b1, PRDS_RESTART_DELAY_OFS, 32'h00);
    bus(1'b1, PRDS_STEERING_OFS, 32'h12);
    cyc(3);
    settle;
    chk("steer a held", 32'h1, {31'h0, act_a});
    @(posedge clk);
    period_start <= 1'b1;
    @(posedge clk);
    period_start <= 1'b0;
    cyc(1);
    settle;
    chk("steer a", 32'h0, {31'h0, act_a});
    bus(1'b1, PRDS_STEERING_OFS, 32'h01);
    cyc(2);
    settle;
    chk("steer b", 32'h0, {31'h0, act_b});
    shut_pulse;
    cyc(5);
    settle;
    chk("shutdown", 32'h1, {31'h0, sd_act});
    chk("load a", 32'h0, {31'h0, on_a});
    rchk(PRDS_STATUS_OFS, 32'h1);
    bus(1'b1, PRDS_STATUS_OFS, 32'h0);
    cyc(4);
    settle;
    chk("shutdown", 32'h0, {31'h0, sd_act});
    chk("load a", 32'h1, {31'h0, on_a});
    bus(1'b1, PRDS_RESTART_DELAY_OFS, 32'h80);
    shut_pulse;
    settle;
    chk("shutdown", 32'h1, {31'h0, sd_act});
    cyc(4);
    settle;
    chk("restart", 32'h0, {31'h0, sd_act});
    finish_test;
  end
endmodule
